/* File: hw/aoc_pkg.sv */
// aoc_pkg: register indexes, field positions, reset values and codes of the output control bank
`default_nettype none
package aoc_pkg;
	// ----------------------------------------------------------------
	// register indexes (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [9:0] IDX_LVDS_PAIR_POLARITY   = 10'h065;
	localparam logic [9:0] IDX_GLOBAL_OFFSET_LOW    = 10'h066;
	localparam logic [9:0] IDX_GLOBAL_OFFSET_HIGH   = 10'h067;
	localparam logic [9:0] IDX_WORD_CLOCK_OVR_CTRL  = 10'h068;
	localparam logic [9:0] IDX_PLL_RECALIBRATION    = 10'h06b;
	localparam logic [9:0] IDX_PLL_CLOCK_GATE_DELAY = 10'h06d;
	localparam logic [9:0] IDX_USER_PATTERN_A_LOW   = 10'h074;
	localparam logic [9:0] IDX_USER_PATTERN_A_HIGH  = 10'h075;
	localparam logic [9:0] IDX_USER_PATTERN_B_LOW   = 10'h076;
	localparam logic [9:0] IDX_USER_PATTERN_B_HIGH  = 10'h077;
	localparam logic [9:0] IDX_PATH_CONTROL         = 10'h080;
	localparam logic [9:0] IDX_PLL_STATUS           = 10'h0d1;
	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_LVDS_PAIR_POLARITY   = 8'h00;
	localparam logic [7:0] RST_GLOBAL_OFFSET        = 8'h00;
	localparam logic [7:0] RST_WORD_CLOCK_OVR_CTRL  = 8'h24;
	localparam logic [7:0] RST_PLL_RECALIBRATION    = 8'h08;
	localparam logic [7:0] RST_PLL_CLOCK_GATE_DELAY = 8'h00;
	localparam logic [7:0] RST_USER_PATTERN         = 8'h00;
	localparam logic [7:0] RST_PATH_CONTROL         = 8'h00;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int POS_PAIR_INVERT_MASK = 2;
	localparam int POS_AUX_PAIR_INVERT  = 3;
	localparam int POS_AUX_PAIR_ENABLE  = 2;
	localparam int POS_PLL_RECAL_TOGGLE = 2;
	localparam int POS_PLL_CLK_ENABLE   = 5;
	localparam int POS_OUT_CLK_DELAY    = 1;
	localparam int POS_PATTERN_NIBBLE   = 4;
	localparam int POS_CLK_SRC_PLL      = 3;
	localparam int POS_PLL_ENABLE       = 4;
	localparam int POS_DECIM_ACTIVE     = 5;
	localparam int POS_CAL_BUSY         = 0;
	localparam int POS_CAL_DONE         = 1;
	localparam logic [7:0] MASK_PLL_CLOCK_GATE_DELAY = 8'h3f;
	localparam logic [7:0] MASK_PATH_CONTROL         = 8'h3f;
	// ----------------------------------------------------------------
	// codes
	// ----------------------------------------------------------------
	localparam logic [2:0] PAT_DOUBLE_CUSTOM = 3'h1;
	localparam logic [1:0] RESP_OKAY         = 2'h0;
	localparam logic [1:0] RESP_SLVERR       = 2'h2;
	localparam int         OFFSET_FRAC_BITS  = 3;
	// vco delay per code; code 7 gives 15 cycles
	localparam logic [3:0] DLY_CYCLES [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'he, 4'hf};
endpackage : aoc_pkg
`default_nettype wire

/* File: hw/aoc_regs.sv */
// aoc_regs: output control register bank with AXI4-Lite slave, offset adder and clock gating
//
// Local design decision: register access over AXI4-Lite.
`default_nettype none
module aoc_regs
	import aoc_pkg::*;
#(
	parameter int CAL_CYCLES = 64
)(
	// clock, reset, enable
	input  wire logic        CORE_CLK_I,
	input  wire logic        RESETN_I,
	input  wire logic        CORE_CE_I,
	// axi4-lite write
	input  wire logic [11:0] AWADDR_I,
	input  wire logic        AWVALID_I,
	output logic             AWREADY_O,
	input  wire logic [31:0] WDATA_I,
	input  wire logic [3:0]  WSTRB_I,
	input  wire logic        WVALID_I,
	output logic             WREADY_O,
	output logic [1:0]       BRESP_O,
	output logic             BVALID_O,
	input  wire logic        BREADY_I,
	// axi4-lite read
	input  wire logic [11:0] ARADDR_I,
	input  wire logic        ARVALID_I,
	output logic             ARREADY_O,
	output logic [31:0]      RDATA_O,
	output logic [1:0]       RRESP_O,
	output logic             RVALID_O,
	input  wire logic        RREADY_I,
	// converter samples
	input  wire logic [11:0] CONV_DATA_I,
	input  wire logic        CONV_OVR_I,
	input  wire logic        CONV_VALID_I,
	// output stage
	output logic [11:0]      OUT_DATA_O,
	output logic             OUT_VALID_O,
	output logic [5:0]       PAIR_INVERT_MASK_O,
	output logic             WORD_CLOCK_OUT_O,
	output logic             OVERRANGE_OUT_O,
	output logic             AUX_PAIR_ENABLE_O,
	// clock path
	output logic             PLL_CLK_GATE_O,
	output logic [3:0]       OUT_CLOCK_VCO_DELAY_O,
	output logic             PLL_RECAL_START_O
);
	import aoc_pkg::*;

	// the calibration counter is 16 bits wide
	if (CAL_CYCLES < 1 || CAL_CYCLES > 65535)
	begin : g_bad_cal
		$error("CAL_CYCLES out of range");
	end

	localparam logic [15:0] CAL_LOAD = 16'(CAL_CYCLES);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        aw_got;
		logic        w_got;
		logic [9:0]  aw_idx;
		logic [7:0]  w_byte;
		logic        w_lane0;
		logic        arready;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [7:0]  rdata;
		logic [7:0]  pol;
		logic [7:0]  off_lo;
		logic [7:0]  off_hi;
		logic [7:0]  aux;
		logic [7:0]  cal;
		logic [7:0]  pll;
		logic [7:0]  pa_lo;
		logic [7:0]  pa_hi;
		logic [7:0]  pb_lo;
		logic [7:0]  pb_hi;
		logic [7:0]  ctl;
		logic        cal_prev;
		logic [15:0] cal_cnt;
		logic        cal_start;
		logic        cal_done;
		logic [11:0] out_data;
		logic        out_valid;
		logic        word_clock_out;
		logic        overrange_out;
		logic        aux_en;
		logic [5:0]  inv_mask;
		logic        pll_gate;
		logic [3:0]  clk_dly;
		logic        sel_b;
		logic        wck_phase;
	} aoc_state_s;

	aoc_state_s s;
	aoc_state_s next_s;

	// ----------------------------------------------------------------
	// datapath helpers
	// ----------------------------------------------------------------
	logic        [11:0] pair_bits;
	logic signed [15:0] offset_value;
	logic signed [16:0] offset_sum;
	logic signed [13:0] offset_int;
	logic        [11:0] sample_word;
	logic               sample_sat;
	logic        [11:0] pattern_a;
	logic        [11:0] pattern_b;

	// one mask bit flips both bits of its ddr pair
	for (genvar k = 0; k < 6; k++)
	begin : g_pair
		assign pair_bits[2*k+1:2*k] = {2{s.pol[POS_PAIR_INVERT_MASK+k]}};
	end

	assign offset_value = signed'({s.off_hi, s.off_lo});
	// 1/8 lsb resolution: sample carries three fraction bits before the add
	assign offset_sum = 17'(signed'({CONV_DATA_I, 3'h0})) + 17'(offset_value);
	assign offset_int = offset_sum[16:OFFSET_FRAC_BITS];
	// saturate rather than wrap so a large offset cannot flip sign
	assign sample_sat = (offset_int > 14'sd2047) || (offset_int < -14'sd2048);
	assign sample_word = (offset_int > 14'sd2047) ? 12'h7ff :
		(offset_int < -14'sd2048) ? 12'h800 : offset_int[11:0];

	assign pattern_a = {s.pa_hi, s.pa_lo[7:POS_PATTERN_NIBBLE]};
	assign pattern_b = {s.pb_hi, s.pb_lo[7:POS_PATTERN_NIBBLE]};

	// ----------------------------------------------------------------
	// register read decode
	// ----------------------------------------------------------------
	function automatic logic [8:0] read_reg(input logic [9:0] idx, input aoc_state_s st);
		logic [8:0] r;
		r = {1'b1, 8'h00};
		case (idx)
			IDX_LVDS_PAIR_POLARITY:   r[7:0] = st.pol;
			IDX_GLOBAL_OFFSET_LOW:    r[7:0] = st.off_lo;
			IDX_GLOBAL_OFFSET_HIGH:   r[7:0] = st.off_hi;
			IDX_WORD_CLOCK_OVR_CTRL:  r[7:0] = st.aux;
			IDX_PLL_RECALIBRATION:    r[7:0] = st.cal;
			IDX_PLL_CLOCK_GATE_DELAY: r[7:0] = st.pll & MASK_PLL_CLOCK_GATE_DELAY;
			IDX_USER_PATTERN_A_LOW:   r[7:0] = st.pa_lo;
			IDX_USER_PATTERN_A_HIGH:  r[7:0] = st.pa_hi;
			IDX_USER_PATTERN_B_LOW:   r[7:0] = st.pb_lo;
			IDX_USER_PATTERN_B_HIGH:  r[7:0] = st.pb_hi;
			IDX_PATH_CONTROL:         r[7:0] = st.ctl;
			IDX_PLL_STATUS:
			begin
				r[POS_CAL_BUSY] = (st.cal_cnt != 16'h0000);
				r[POS_CAL_DONE] = st.cal_done;
			end
			default:                  r = 9'h000;
		endcase
		return r;
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		logic       aw_fire;
		logic       w_fire;
		logic       ar_fire;
		logic [9:0] widx;
		logic [7:0] wbyte;
		logic       lane0;
		logic [8:0] rd;
		logic       pll_ok;
		logic [11:0] word;
		logic       wck_raw;
		logic       ovr_raw;
		logic [8:0] wr_chk;
		aw_fire = 1'b0;
		w_fire  = 1'b0;
		ar_fire = 1'b0;
		widx    = 10'h000;
		wbyte   = 8'h00;
		lane0   = 1'b0;
		rd      = 9'h000;
		pll_ok  = 1'b0;
		word    = 12'h000;
		wck_raw = 1'b0;
		ovr_raw = 1'b0;
		wr_chk  = 9'h000;
		next_s  = s;

		// write channel: address and data in either order
		aw_fire = AWVALID_I && s.awready;
		w_fire  = WVALID_I && s.wready;
		widx    = aw_fire ? AWADDR_I[11:2] : s.aw_idx;
		wbyte   = w_fire ? WDATA_I[7:0] : s.w_byte;
		lane0   = w_fire ? WSTRB_I[0] : s.w_lane0;
		if (aw_fire)
		begin
			next_s.aw_got  = 1'b1;
			next_s.awready = 1'b0;
			next_s.aw_idx  = AWADDR_I[11:2];
		end
		if (w_fire)
		begin
			next_s.w_got   = 1'b1;
			next_s.wready  = 1'b0;
			next_s.w_byte  = WDATA_I[7:0];
			next_s.w_lane0 = WSTRB_I[0];
		end
		if ((s.aw_got || aw_fire) && (s.w_got || w_fire))
		begin
			next_s.aw_got = 1'b0;
			next_s.w_got  = 1'b0;
			next_s.bvalid = 1'b1;
			wr_chk        = read_reg(widx, s);
			next_s.bresp  = wr_chk[8] ? RESP_OKAY : RESP_SLVERR;
			// only byte lane 0 carries register data
			if (lane0)
			begin
				case (widx)
					IDX_LVDS_PAIR_POLARITY:   next_s.pol = wbyte;
					IDX_GLOBAL_OFFSET_LOW:    next_s.off_lo = wbyte;
					IDX_GLOBAL_OFFSET_HIGH:   next_s.off_hi = wbyte;
					IDX_WORD_CLOCK_OVR_CTRL:  next_s.aux = wbyte;
					IDX_PLL_RECALIBRATION:    next_s.cal = wbyte;
					IDX_PLL_CLOCK_GATE_DELAY: next_s.pll = wbyte & MASK_PLL_CLOCK_GATE_DELAY;
					IDX_USER_PATTERN_A_LOW:   next_s.pa_lo = wbyte;
					IDX_USER_PATTERN_A_HIGH:  next_s.pa_hi = wbyte;
					IDX_USER_PATTERN_B_LOW:   next_s.pb_lo = wbyte;
					IDX_USER_PATTERN_B_HIGH:  next_s.pb_hi = wbyte;
					IDX_PATH_CONTROL:         next_s.ctl = wbyte & MASK_PATH_CONTROL;
					default:                  next_s.pol = s.pol;
				endcase
			end
		end
		if (s.bvalid && BREADY_I)
		begin
			next_s.bvalid  = 1'b0;
			next_s.awready = 1'b1;
			next_s.wready  = 1'b1;
		end

		// read channel
		ar_fire = ARVALID_I && s.arready;
		if (ar_fire)
		begin
			rd             = read_reg(ARADDR_I[11:2], s);
			next_s.arready = 1'b0;
			next_s.rvalid  = 1'b1;
			next_s.rdata   = rd[7:0];
			next_s.rresp   = rd[8] ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s.rvalid && RREADY_I)
		begin
			next_s.rvalid  = 1'b0;
			next_s.arready = 1'b1;
		end

		// recalibration: edge of the toggle bit, not its level
		next_s.cal_start = 1'b0;
		if (s.cal[POS_PLL_RECAL_TOGGLE] != s.cal_prev)
		begin
			next_s.cal_prev  = s.cal[POS_PLL_RECAL_TOGGLE];
			next_s.cal_start = 1'b1;
			next_s.cal_cnt   = CAL_LOAD;
			next_s.cal_done  = 1'b0;
		end
		else if (s.cal_cnt != 16'h0000)
		begin
			next_s.cal_cnt = s.cal_cnt - 16'h0001;
			if (s.cal_cnt == 16'h0001)
				next_s.cal_done = 1'b1;
		end

		// clock path
		pll_ok = s.ctl[POS_CLK_SRC_PLL] && s.ctl[POS_PLL_ENABLE];
		next_s.pll_gate = pll_ok && s.pll[POS_PLL_CLK_ENABLE];
		next_s.clk_dly  = (pll_ok && !s.ctl[POS_DECIM_ACTIVE]) ?
			DLY_CYCLES[s.pll[POS_OUT_CLK_DELAY +: 3]] : 4'h0;

		// output stage
		next_s.inv_mask  = s.pol[7:POS_PAIR_INVERT_MASK];
		next_s.aux_en    = s.aux[POS_AUX_PAIR_ENABLE];
		next_s.out_valid = CONV_VALID_I;
		if (CONV_VALID_I)
		begin
			next_s.wck_phase = !s.wck_phase;
			if (s.ctl[2:0] == PAT_DOUBLE_CUSTOM)
			begin
				word         = s.sel_b ? pattern_b : pattern_a;
				next_s.sel_b = !s.sel_b;
				wck_raw      = word[10];
				ovr_raw      = word[11];
			end
			else
			begin
				word         = sample_word;
				next_s.sel_b = 1'b0;
				wck_raw      = !s.wck_phase;
				ovr_raw      = CONV_OVR_I || sample_sat;
			end
			next_s.out_data = word ^ pair_bits;
			// disabled pair idles low
			next_s.word_clock_out = s.aux[POS_AUX_PAIR_ENABLE] &&
				(wck_raw ^ s.aux[POS_AUX_PAIR_INVERT]);
			next_s.overrange_out = s.aux[POS_AUX_PAIR_ENABLE] &&
				(ovr_raw ^ s.aux[POS_AUX_PAIR_INVERT]);
		end
		// drop the pair at once, even while no samples arrive
		if (!s.aux[POS_AUX_PAIR_ENABLE])
		begin
			next_s.word_clock_out = 1'b0;
			next_s.overrange_out = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			s         <= '0;
			s.awready <= 1'b1;
			s.wready  <= 1'b1;
			s.arready <= 1'b1;
			s.pol     <= RST_LVDS_PAIR_POLARITY;
			s.off_lo  <= RST_GLOBAL_OFFSET;
			s.off_hi  <= RST_GLOBAL_OFFSET;
			s.aux     <= RST_WORD_CLOCK_OVR_CTRL;
			s.cal     <= RST_PLL_RECALIBRATION;
			s.pll     <= RST_PLL_CLOCK_GATE_DELAY;
			s.pa_lo   <= RST_USER_PATTERN;
			s.pa_hi   <= RST_USER_PATTERN;
			s.pb_lo   <= RST_USER_PATTERN;
			s.pb_hi   <= RST_USER_PATTERN;
			s.ctl     <= RST_PATH_CONTROL;
			s.aux_en  <= 1'b1;
		end
		else if (CORE_CE_I)
		begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign AWREADY_O             = s.awready;
	assign WREADY_O              = s.wready;
	assign BVALID_O              = s.bvalid;
	assign BRESP_O               = s.bresp;
	assign ARREADY_O             = s.arready;
	assign RVALID_O              = s.rvalid;
	assign RRESP_O               = s.rresp;
	assign RDATA_O               = {24'h000000, s.rdata};
	assign OUT_DATA_O            = s.out_data;
	assign OUT_VALID_O           = s.out_valid;
	assign PAIR_INVERT_MASK_O    = s.inv_mask;
	assign WORD_CLOCK_OUT_O      = s.word_clock_out;
	assign OVERRANGE_OUT_O       = s.overrange_out;
	assign AUX_PAIR_ENABLE_O     = s.aux_en;
	assign PLL_CLK_GATE_O        = s.pll_gate;
	assign OUT_CLOCK_VCO_DELAY_O = s.clk_dly;
	assign PLL_RECAL_START_O     = s.cal_start;

endmodule : aoc_regs
`default_nettype wire

/* File: hw/aoc_fix_note.sv */
// aoc_fix_note: intentionally empty compile unit
`default_nettype none
`default_nettype wire

/* File: test/aoc_regs_props.sv */
// aoc_regs_props: port-level checks of the output control bank
`default_nettype none
module aoc_regs_props #(
	parameter int CAL_CYCLES = 64
)(
	// clock and reset
	input wire logic        CORE_CLK_I,
	input wire logic        RESETN_I,
	input wire logic        CORE_CE_I,
	// register bus
	input wire logic        AWVALID_I,
	input wire logic        AWREADY_O,
	input wire logic        WVALID_I,
	input wire logic        WREADY_O,
	input wire logic        BVALID_O,
	input wire logic        BREADY_I,
	input wire logic        ARVALID_I,
	input wire logic        ARREADY_O,
	input wire logic [31:0] RDATA_O,
	input wire logic        RVALID_O,
	// output stage
	input wire logic        CONV_VALID_I,
	input wire logic        OUT_VALID_O,
	input wire logic        WORD_CLOCK_OUT_O,
	input wire logic        OVERRANGE_OUT_O,
	input wire logic        AUX_PAIR_ENABLE_O,
	input wire logic        PLL_RECAL_START_O
);
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (!RESETN_I);
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_out_valid_delay: assert property (CORE_CE_I |=> OUT_VALID_O == $past(CONV_VALID_I))
		else $error("output valid not one cycle after sample");
	a_write_answer: assert property (CORE_CE_I && AWVALID_I && AWREADY_O && WVALID_I
		&& WREADY_O |=> BVALID_O && !AWREADY_O && !WREADY_O)
		else $error("write not answered one cycle after take");
	a_bresp_stands: assert property (BVALID_O && !BREADY_I |=> BVALID_O)
		else $error("write response dropped before handshake");
	a_write_refused: assert property (BVALID_O |-> !AWREADY_O && !WREADY_O)
		else $error("write accepted while response pending");
	a_read_answer: assert property (CORE_CE_I && ARVALID_I && ARREADY_O |=> RVALID_O && !ARREADY_O)
		else $error("read not answered one cycle after take");
	a_read_upper_zero: assert property (RVALID_O |-> RDATA_O[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	a_aux_pair_off: assert property (!AUX_PAIR_ENABLE_O
		|-> !WORD_CLOCK_OUT_O && !OVERRANGE_OUT_O)
		else $error("disabled aux pair still driven");
	a_recal_single: assert property (PLL_RECAL_START_O && CORE_CE_I |=> !PLL_RECAL_START_O)
		else $error("recalibration start longer than one cycle");
	c_write: cover property (BVALID_O && BREADY_I);
	c_read: cover property (RVALID_O);
	c_recal: cover property (PLL_RECAL_START_O);
endmodule // aoc_regs_props
bind aoc_regs aoc_regs_props #(.CAL_CYCLES(CAL_CYCLES)) u_props (
	.CORE_CLK_I, .RESETN_I, .CORE_CE_I, .AWVALID_I, .AWREADY_O, .WVALID_I, .WREADY_O,
	.BVALID_O, .BREADY_I, .ARVALID_I, .ARREADY_O, .RDATA_O, .RVALID_O, .CONV_VALID_I,
	.OUT_VALID_O, .WORD_CLOCK_OUT_O, .OVERRANGE_OUT_O, .AUX_PAIR_ENABLE_O, .PLL_RECAL_START_O
);
`default_nettype wire

/* File: test/aoc_host.sv */
// aoc_host: AXI4-Lite host model that programs the bank
`default_nettype none
module aoc_host (
	// clock
	input  wire logic        clk_i,
	// write channels
	output logic [11:0]      awaddr_o,
	output logic             awvalid_o,
	input  wire logic        awready_i,
	output logic [31:0]      wdata_o,
	output logic [3:0]       wstrb_o,
	output logic             wvalid_o,
	input  wire logic        wready_i,
	input  wire logic [1:0]  bresp_i,
	input  wire logic        bvalid_i,
	output logic             bready_o,
	// read channels
	output logic [11:0]      araddr_o,
	output logic             arvalid_o,
	input  wire logic        arready_i,
	input  wire logic [31:0] rdata_i,
	input  wire logic [1:0]  rresp_i,
	input  wire logic        rvalid_i,
	output logic             rready_o
);
	// ----------------------------------------------------------------
	// bus cycles
	// ----------------------------------------------------------------
	// cycles before ready is raised, to exercise a slow host
	int lag = 0;
	// byte strobes of the next write; zero exercises a masked write
	logic [3:0] strb = 4'h1;
	initial
	begin
		{awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o} = 5'h0;
		{awaddr_o, araddr_o, wdata_o} = 56'h0;
		wstrb_o = 4'h1;
	end
	// released lines flip so stale values cannot pass
	task automatic wr(input logic [9:0] i, input logic [7:0] d, output logic [1:0] r);
		int n;
		@(posedge clk_i);
		awaddr_o <= {i, 2'b00};
		wdata_o <= {24'h0, d};
		wstrb_o <= strb;
		awvalid_o <= 1'b1;
		wvalid_o <= 1'b1;
		bready_o <= (lag == 0);
		n = 0;
		forever
		begin
			@(posedge clk_i);
			if (bvalid_i && bready_o) break;
			if (awready_i) {awvalid_o, awaddr_o} <= {1'b0, ~awaddr_o};
			if (wready_i) {wvalid_o, wdata_o} <= {1'b0, ~wdata_o};
			n++;
			if (n >= lag) bready_o <= 1'b1;
		end
		r = bresp_i;
		bready_o <= 1'b0;
	endtask
	task automatic rd(input logic [9:0] i, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge clk_i);
		araddr_o <= {i, 2'b00};
		arvalid_o <= 1'b1;
		rready_o <= (lag == 0);
		n = 0;
		forever
		begin
			@(posedge clk_i);
			if (rvalid_i && rready_o) break;
			if (arready_i) {arvalid_o, araddr_o} <= {1'b0, ~araddr_o};
			n++;
			if (n >= lag) rready_o <= 1'b1;
		end
		d = rdata_i;
		r = rresp_i;
		rready_o <= 1'b0;
	endtask
endmodule // aoc_host
`default_nettype wire

/* File: test/aoc_regs_tb.sv */
// aoc_regs_tb: self-checking bench of the output control bank
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
	$display("Error %0t got %h exp %h", $time, (a), (b)); end end
module aoc_regs_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import aoc_pkg::*;
	// ----------------------------------------------------------------
	// bench
	// ----------------------------------------------------------------
	// short calibration keeps the run small
	localparam int CAL = 16;
	logic CORE_CLK_I = 1'b0, RESETN_I = 1'b0, CORE_CE_I = 1'b1;
	logic CONV_OVR_I = 1'b0, CONV_VALID_I = 1'b0;
	logic [11:0] CONV_DATA_I = 12'h0, AWADDR_I, ARADDR_I, OUT_DATA_O, pa, pb, p;
	logic [31:0] WDATA_I, RDATA_O, sd = 32'h3394a1a9, x, q;
	logic [3:0] WSTRB_I, OUT_CLOCK_VCO_DELAY_O;
	logic [1:0] BRESP_O, RRESP_O, r;
	logic [5:0] PAIR_INVERT_MASK_O, m;
	logic [15:0] f;
	logic [12:0] e;
	logic AWVALID_I, AWREADY_O, WVALID_I, WREADY_O, BVALID_O, BREADY_I, ARVALID_I, ARREADY_O;
	logic RVALID_O, RREADY_I, OUT_VALID_O, WORD_CLOCK_OUT_O, OVERRANGE_OUT_O, AUX_PAIR_ENABLE_O;
	logic PLL_CLK_GATE_O, PLL_RECAL_START_O;
	logic ph = 1'b0;
	int miscompares = 0, checked = 0, pulses = 0, p0;
	logic [9:0] ri [11] = '{10'h065, 10'h066, 10'h067, 10'h068, 10'h06b, 10'h06d, 10'h074,
		10'h075, 10'h076, 10'h077, 10'h080};
	logic [7:0] rv [11] = '{8'h00, 8'h00, 8'h00, 8'h24, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00};
	aoc_regs #(.CAL_CYCLES(CAL)) DUT (
		.CORE_CLK_I, .RESETN_I, .CORE_CE_I, .AWADDR_I, .AWVALID_I, .AWREADY_O, .WDATA_I,
		.WSTRB_I, .WVALID_I, .WREADY_O, .BRESP_O, .BVALID_O, .BREADY_I, .ARADDR_I, .ARVALID_I,
		.ARREADY_O, .RDATA_O, .RRESP_O, .RVALID_O, .RREADY_I, .CONV_DATA_I, .CONV_OVR_I,
		.CONV_VALID_I, .OUT_DATA_O, .OUT_VALID_O, .PAIR_INVERT_MASK_O, .WORD_CLOCK_OUT_O,
		.OVERRANGE_OUT_O, .AUX_PAIR_ENABLE_O, .PLL_CLK_GATE_O, .OUT_CLOCK_VCO_DELAY_O,
		.PLL_RECAL_START_O
	);
	aoc_host HOST (
		.clk_i(CORE_CLK_I), .awaddr_o(AWADDR_I), .awvalid_o(AWVALID_I), .awready_i(AWREADY_O),
		.wdata_o(WDATA_I), .wstrb_o(WSTRB_I), .wvalid_o(WVALID_I), .wready_i(WREADY_O),
		.bresp_i(BRESP_O), .bvalid_i(BVALID_O), .bready_o(BREADY_I), .araddr_o(ARADDR_I),
		.arvalid_o(ARVALID_I), .arready_i(ARREADY_O), .rdata_i(RDATA_O), .rresp_i(RRESP_O),
		.rvalid_i(RVALID_O), .rready_o(RREADY_I)
	);
	always #5 CORE_CLK_I = ~CORE_CLK_I;
	always @(posedge CORE_CLK_I) if (PLL_RECAL_START_O === 1'b1) pulses++;
	function automatic logic [31:0] rnd();
		sd = {sd[30:0], 1'b0} ^ (sd[31] ? 32'h04c11db7 : 32'h0);
		return sd;
	endfunction
	function automatic logic [11:0] inv(input logic [5:0] mk);
		for (int k = 0; k < 6; k++)
			inv[2*k+:2] = {2{mk[k]}};
	endfunction
	// sample plus offset in eighths, floored, then clipped; top bit flags clipping
	function automatic logic [12:0] expn(input logic [11:0] s, input logic [15:0] fo);
		int v;
		v = (($signed(s) * 8) + $signed(fo)) >>> 3;
		if (v > 2047) return 13'h17ff;
		if (v < -2048) return 13'h1800;
		return {1'b0, v[11:0]};
	endfunction
	task automatic settle();
		@(posedge CORE_CLK_I);
		#1;
	endtask
	task automatic smp(input logic [11:0] d, input logic ov);
		@(posedge CORE_CLK_I);
		ph = ~ph;
		CONV_DATA_I <= d;
		CONV_OVR_I <= ov;
		CONV_VALID_I <= 1'b1;
		@(posedge CORE_CLK_I);
		CONV_VALID_I <= 1'b0;
		CONV_DATA_I <= ~d;
		#1;
		`CHK(OUT_VALID_O, 1'b1)
	endtask
	task automatic summarize();
		if (miscompares == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		#100us;
		miscompares++;
		summarize();
	end
	initial
	begin
		repeat (10) @(posedge CORE_CLK_I);
		RESETN_I <= 1'b1;
		settle();
		`CHK({PLL_CLK_GATE_O, AUX_PAIR_ENABLE_O}, 2'b01)
		for (int k = 0; k < 11; k++)
		begin
			HOST.rd(ri[k], q, r);
			`CHK(q, {24'h0, rv[k]})
		end
		HOST.lag = 3;
		HOST.wr(10'h3ff, 8'hff, r);
		`CHK(r, RESP_SLVERR)
		HOST.rd(10'h3ff, q, r);
		`CHK({r, q}, {RESP_SLVERR, 32'h0})
		HOST.lag = 0;
		for (int k = 0; k < 6; k++)
		begin
			x = (k == 0) ? 32'hfc : (k == 1) ? 32'h80 : (k == 2) ? 32'h04 : rnd();
			HOST.wr(10'h065, x[7:0], r);
			HOST.rd(10'h065, q, r);
			`CHK(q, {24'h0, x[7:0]})
			`CHK(PAIR_INVERT_MASK_O, x[7:2])
		end
		HOST.strb = 4'h0;
		HOST.wr(10'h065, ~x[7:0], r);
		HOST.strb = 4'h1;
		HOST.rd(10'h065, q, r);
		`CHK({r, q}, {RESP_OKAY, 24'h0, x[7:0]})
		m = x[7:2];
		for (int k = 0; k < 4; k++)
		begin
			x = rnd();
			f = (k == 0) ? 16'h7fff : (k == 1) ? 16'h8000 : x[15:0];
			HOST.wr(10'h066, f[7:0], r);
			HOST.wr(10'h067, f[15:8], r);
			for (int j = 0; j < 6; j++)
			begin
				x = rnd();
				if (j == 0) x[11:0] = f[15] ? 12'h800 : 12'h7ff;
				e = expn(x[11:0], f);
				smp(x[11:0], x[12]);
				`CHK(OUT_DATA_O, e[11:0] ^ inv(m))
				`CHK(OVERRANGE_OUT_O, x[12] | e[12])
				`CHK(WORD_CLOCK_OUT_O, ph)
			end
		end
		// clock enable low must freeze the sample path
		@(posedge CORE_CLK_I);
		CORE_CE_I <= 1'b0;
		CONV_VALID_I <= 1'b1;
		repeat (3) @(posedge CORE_CLK_I);
		CORE_CE_I <= 1'b1;
		CONV_VALID_I <= 1'b0;
		#1;
		`CHK({OUT_VALID_O, WORD_CLOCK_OUT_O}, {1'b0, ph})
		HOST.wr(10'h068, 8'h20, r);
		smp(12'h0, 1'b1);
		`CHK({AUX_PAIR_ENABLE_O, WORD_CLOCK_OUT_O, OVERRANGE_OUT_O}, 3'b000)
		HOST.wr(10'h068, 8'h2c, r);
		x = rnd();
		pa = x[11:0];
		pb = x[27:16];
		HOST.wr(10'h075, pa[11:4], r);
		HOST.wr(10'h074, {pa[3:0], 4'h0}, r);
		HOST.wr(10'h077, pb[11:4], r);
		HOST.wr(10'h076, {pb[3:0], 4'h0}, r);
		HOST.wr(10'h080, {5'h0, PAT_DOUBLE_CUSTOM}, r);
		for (int k = 0; k < 4; k++)
		begin
			p = k[0] ? pb : pa;
			x = rnd();
			smp(x[11:0], x[12]);
			`CHK(OUT_DATA_O, p ^ inv(m))
			`CHK(WORD_CLOCK_OUT_O, ~p[10])
			`CHK(OVERRANGE_OUT_O, ~p[11])
		end
		HOST.wr(10'h080, 8'h18, r);
		for (int c = 0; c < 8; c++)
		begin
			HOST.wr(10'h06d, {4'he, c[2:0], 1'b0}, r);
			HOST.rd(10'h06d, q, r);
			`CHK(q, {26'h0, 2'b10, c[2:0], 1'b0})
			`CHK({PLL_CLK_GATE_O, OUT_CLOCK_VCO_DELAY_O}, {1'b1, DLY_CYCLES[c]})
		end
		HOST.wr(10'h080, 8'h38, r);
		settle();
		`CHK(OUT_CLOCK_VCO_DELAY_O, 4'h0)
		HOST.wr(10'h080, 8'h10, r);
		settle();
		`CHK(PLL_CLK_GATE_O, 1'b0)
		p0 = pulses;
		HOST.wr(10'h06b, 8'h0c, r);
		HOST.rd(10'h0d1, q, r);
		`CHK(q[0], 1'b1)
		`CHK(pulses, p0 + 1)
		HOST.wr(10'h06b, 8'h0c, r);
		repeat (CAL + 8) @(posedge CORE_CLK_I);
		HOST.rd(10'h0d1, q, r);
		`CHK(q[1:0], 2'b10)
		`CHK(pulses, p0 + 1)
		HOST.wr(10'h06b, 8'h08, r);
		settle();
		`CHK(pulses, p0 + 2)
		summarize();
	end
endmodule // aoc_regs_tb
`default_nettype wire
